// [hw/ptp_cls_cfg.svh]
// Offsets, field positions, reset values and codes of the transmit time-sync classifier.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef PTP_CLS_CFG_SVH
`define PTP_CLS_CFG_SVH

// Register byte addresses
`define A_TS_CTL     8'h00
`define A_REF_SEL    8'h04
`define A_RAW_STAT   8'h08
`define A_POP        8'h0C
`define A_EV_LOW     8'h10
`define A_EV_MID     8'h14
`define A_EV_HIGH    8'h18
`define A_PORT_CTL   8'h20
`define A_ADDR_CTL   8'h24
`define A_CTL_TWO    8'h28
`define A_VLAN       8'h2C

// Field positions
`define B_EN         0
`define B_V4         0
`define B_V6         1
`define B_VA         2
`define B_VB         3
`define B_TTL        4
`define F_MSG        31:16
`define B_UNI        0
`define F_ADDR       5:1
`define B_319        6
`define B_320        7
`define F_SCOPE      15:0
`define F_VLAN_A     15:0
`define F_VLAN_B     31:16

// Reset values
`define RST_WORD     32'h0000_0000
`define RST_SEL      5'h00

// Frame codes
`define T_V6         16'h86DD
`define T_V4         16'h0800
`define V6_NIB       4'h6
`define V4_VH        8'h45
`define UDP          8'h11
`define HOP1         8'h01
`define ZERO8        8'h00
`define MC_FF        8'hFF
`define V4_MC        8'hE0
`define PORT_HI      8'h01
`define P319         8'h3F
`define P320         8'h40
`define ADR_HI_A     8'h01
`define ADR_HI_B     8'h00
`define ADR_129      8'h81
`define ADR_130      8'h82
`define ADR_131      8'h83
`define ADR_132      8'h84
`define ADR_107      8'h6B
`define HOST_PORT    2'h0
`define EV_TX        4'h4

// Untagged byte positions
`define O_TYPE_HI    7'd12
`define O_TYPE_LO    7'd13
`define O_VER        7'd14
`define O_V6_NH      7'd20
`define O_V6_HOP     7'd21
`define O_V6_DST     7'd38
`define O_V6_SCOPE   7'd39
`define O_V6_Z0      7'd40
`define O_V6_Z1      7'd51
`define O_V6_DHI     7'd52
`define O_V6_DLO     7'd53
`define O_V6_PHI     7'd56
`define O_V6_PLO     7'd57
`define O_V6_PTP     7'd62
`define O_V4_FRAG    7'd20
`define O_V4_FRLO    7'd21
`define O_V4_TTL     7'd22
`define O_V4_PROTO   7'd23
`define O_V4_DST     7'd30
`define O_V4_D1      7'd31
`define O_V4_DHI     7'd32
`define O_V4_DLO     7'd33
`define O_V4_PHI     7'd36
`define O_V4_PLO     7'd37
`define O_V4_PTP     7'd42
`define TAG_LEN      7'd4
`define POS_MAX      7'h7F

`endif

// [hw/ptp_cls_pkg.sv]
// Types shared by the transmit time-sync classifier.
// Assumes nothing of its surroundings.
package ptp_cls_pkg;
	typedef logic [31:0] word_t;
	typedef logic [6:0]  pos_t;
	typedef enum logic [1:0] {TAG_NONE = 2'b00, TAG_A = 2'b01, TAG_B = 2'b10} tag_t;
	typedef enum logic [1:0] {KIND_NONE = 2'b00, KIND_V4 = 2'b01, KIND_V6 = 2'b10} kind_t;
endpackage

// [hw/sync_event_fifo.sv]
// Event FIFO of the time-sync module: push at the tail, pop at the head.
// Assumes one clock; clr empties it synchronously.
`timescale 1ns/1ps
`default_nettype none
module sync_event_fifo #(
	parameter int W     = 37,
	parameter int DEPTH = 8,
	parameter int AW    = $clog2(DEPTH)
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          clr,
	// Tail
	input  wire logic          push,
	input  wire logic [W-1:0]  push_data,
	// Head
	input  wire logic          pop,
	output logic      [W-1:0]  head,
	output logic      [AW:0]   count,
	output logic               full,
	output logic               empty
);
	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
			$error("sync_event_fifo: DEPTH must be a power of two, at least 2");
		end
	endgenerate

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic          do_push;
	logic          do_pop;

	assign full    = count == (AW+1)'(DEPTH);
	assign empty   = count == '0;
	// A push into a full FIFO is dropped; the oldest events are kept
	assign do_push = push && !full;
	assign do_pop  = pop && !empty;
	assign head    = mem[rd_q];

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wr_q] <= push_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			count <= '0;
		end else if (clr) begin
			wr_q  <= '0;
			rd_q  <= '0;
			count <= '0;
		end else begin
			if (do_push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (do_pop) begin
				rd_q <= rd_q + 1'b1;
			end
			count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
endmodule
`default_nettype wire

// [hw/ptp_tx_packet_classifier.sv]
// Transmit time-sync classifier with timestamp counter, event FIFO and Wishbone registers.
// Assumes a byte stream from the switch transmit path, synchronous to clk,
// and an SFD pulse from the transmitter that follows the frame's last byte.
`timescale 1ns/1ps
`default_nettype none
`include "ptp_cls_cfg.svh"
module ptp_tx_packet_classifier #(
	parameter int FIFO_DEPTH = 8,
	parameter int SEL_W      = 5
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               nrst,
	// Wishbone slave
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [7:0]         wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire ptp_cls_pkg::word_t wb_dat_i,
	output ptp_cls_pkg::word_t      wb_dat_o,
	output logic                    wb_ack_o,
	// Transmit byte stream
	input  wire logic               tx_valid,
	input  wire logic               tx_first,
	input  wire logic [7:0]         tx_data,
	input  wire logic [1:0]         tx_port,
	input  wire logic               tx_sfd_sent,
	// Status out
	output logic [SEL_W-1:0]        ref_clock_select,
	output logic                    event_pending_raw
);
	import ptp_cls_pkg::*;

	generate
		if (SEL_W < 1 || SEL_W > 32) begin : g_bad
			$error("ptp_tx_packet_classifier: SEL_W must be 1 to 32");
		end
	endgenerate

	localparam int EW = 37;
	localparam int CW = $clog2(FIFO_DEPTH) + 1;

	logic              rst_s1_q;
	logic              rst_n_q;
	logic              ack_q;
	word_t             dat_q;
	logic              en_q;
	logic [SEL_W-1:0]  refsel_q;
	word_t             pctl_q;
	word_t             actl_q;
	logic [15:0]       ctl2_q;
	word_t             vlan_q;
	word_t             ts_q;
	pos_t              idx_q;
	pos_t              shift_q;
	tag_t              tag_q;
	kind_t             kind_q;
	logic              fail_q;
	logic              host_q;
	logic [7:0]        type_hi_q;
	logic [7:0]        addr_hi_q;
	logic              pend_q;
	logic              pend_v6_q;
	logic [3:0]        pend_mt_q;
	pos_t              pos;
	pos_t              rel;
	logic [15:0]       tval;
	logic              bad;
	logic              qual;
	logic              acc;
	logic              wr;
	logic              pop;
	logic              push;
	logic [EW-1:0]     head;
	logic [CW-1:0]     cnt;
	logic              full;
	logic              empty;
	logic              uni;
	logic [15:0]       msg_en;
	word_t             rd_d;

	function automatic word_t merge(word_t o, word_t n, logic [3:0] s);
		word_t r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = n[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic addr_ok(logic [7:0] hi, logic [7:0] lo, logic [4:0] e);
		return (hi == `ADR_HI_A && ((lo == `ADR_129 && e[0]) || (lo == `ADR_130 && e[1]) ||
			(lo == `ADR_131 && e[2]) || (lo == `ADR_132 && e[3]))) ||
			(hi == `ADR_HI_B && lo == `ADR_107 && e[4]);
	endfunction

	function automatic logic port_ok(logic [7:0] lo, logic e319, logic e320);
		return (lo == `P319 && e319) || (lo == `P320 && e320);
	endfunction

	// Reset release through two flops
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	assign acc    = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr     = acc && wb_we_i;
	assign pop    = wr && wb_adr_i == `A_POP && wb_sel_i[0] && wb_dat_i[0];
	assign uni    = actl_q[`B_UNI];
	assign msg_en = pctl_q[`F_MSG];

	// Bus answer: ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ack_q <= 1'b0;
			dat_q <= `RST_WORD;
		end else begin
			ack_q <= acc;
			if (acc && !wb_we_i) begin
				dat_q <= rd_d;
			end
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	always_comb begin
		rd_d = `RST_WORD;
		case (wb_adr_i)
			`A_TS_CTL:   rd_d[`B_EN] = en_q;
			`A_REF_SEL:  rd_d[SEL_W-1:0] = refsel_q;
			`A_RAW_STAT: rd_d[0] = event_pending_raw;
			`A_EV_LOW:   rd_d = empty ? `RST_WORD : head[31:0];
			`A_EV_MID:   rd_d[7:0] = empty ? `ZERO8 : {`EV_TX, head[35:32]};
			`A_EV_HIGH:  rd_d[0] = !empty && head[36];
			`A_PORT_CTL: rd_d = pctl_q;
			`A_ADDR_CTL: rd_d = actl_q;
			`A_CTL_TWO:  rd_d[15:0] = ctl2_q;
			`A_VLAN:     rd_d = vlan_q;
			default:     rd_d = `RST_WORD;
		endcase
	end

	// Software registers
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			en_q     <= 1'b0;
			refsel_q <= SEL_W'(`RST_SEL);
			pctl_q   <= `RST_WORD;
			actl_q   <= `RST_WORD;
			ctl2_q   <= 16'(`RST_WORD);
			vlan_q   <= `RST_WORD;
		end else if (wr) begin
			case (wb_adr_i)
				`A_TS_CTL: begin
					if (wb_sel_i[0]) begin
						en_q <= wb_dat_i[`B_EN];
					end
				end
				`A_REF_SEL: begin
					// Mux change while running would glitch the time base
					if (!en_q) begin
						refsel_q <= SEL_W'(merge(32'(refsel_q), wb_dat_i, wb_sel_i));
					end
				end
				`A_PORT_CTL: pctl_q <= merge(pctl_q, wb_dat_i, wb_sel_i);
				`A_ADDR_CTL: actl_q <= merge(actl_q, wb_dat_i, wb_sel_i);
				`A_CTL_TWO:  ctl2_q <= 16'(merge({16'h0000, ctl2_q}, wb_dat_i, wb_sel_i));
				`A_VLAN:     vlan_q <= merge(vlan_q, wb_dat_i, wb_sel_i);
				default: ;
			endcase
		end
	end
	assign ref_clock_select = refsel_q;

	// Time base, cleared while the module is disabled
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ts_q <= `RST_WORD;
		end else if (!en_q) begin
			ts_q <= `RST_WORD;
		end else begin
			ts_q <= ts_q + 32'h0000_0001;
		end
	end

	// Byte position relative to an untagged frame
	always_comb begin
		pos  = tx_first ? '0 : idx_q;
		rel  = pos - shift_q;
		tval = {type_hi_q, tx_data};
		bad  = 1'b0;
		qual = 1'b0;
		if (kind_q == KIND_V6) begin
			case (rel) inside
				`O_VER:      bad = tx_data[7:4] != `V6_NIB;
				`O_V6_NH:    bad = tx_data != `UDP;
				`O_V6_HOP:   bad = tx_data != `HOP1;
				`O_V6_DST:   bad = !uni && tx_data != `MC_FF;
				`O_V6_SCOPE: bad = !uni && (tx_data[7:4] != 4'h0 || !ctl2_q[tx_data[3:0]]);
				[`O_V6_Z0:`O_V6_Z1]: bad = !uni && tx_data != `ZERO8;
				`O_V6_DLO:   bad = !uni && !addr_ok(addr_hi_q, tx_data, actl_q[`F_ADDR]);
				`O_V6_PHI:   bad = tx_data != `PORT_HI;
				`O_V6_PLO:   bad = !port_ok(tx_data, actl_q[`B_319], actl_q[`B_320]);
				`O_V6_PTP:   qual = !fail_q && host_q && msg_en[tx_data[3:0]];
				default: ;
			endcase
		end else if (kind_q == KIND_V4) begin
			case (rel)
				`O_VER:      bad = tx_data != `V4_VH;
				`O_V4_FRAG:  bad = tx_data[4:0] != 5'h00;
				`O_V4_FRLO:  bad = tx_data != `ZERO8;
				`O_V4_TTL:   bad = !pctl_q[`B_TTL] && tx_data != `ZERO8;
				`O_V4_PROTO: bad = tx_data != `UDP;
				`O_V4_DST:   bad = !uni && tx_data != `V4_MC;
				`O_V4_D1:    bad = !uni && tx_data != `ZERO8;
				`O_V4_DLO:   bad = !uni && !addr_ok(addr_hi_q, tx_data, actl_q[`F_ADDR]);
				`O_V4_PHI:   bad = tx_data != `PORT_HI;
				`O_V4_PLO:   bad = !port_ok(tx_data, actl_q[`B_319], actl_q[`B_320]);
				`O_V4_PTP:   qual = !fail_q && host_q && msg_en[tx_data[3:0]];
				default: ;
			endcase
		end
		qual = qual && tx_valid && !tx_first;
	end

	// Frame parser state
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			idx_q     <= '0;
			shift_q   <= '0;
			tag_q     <= TAG_NONE;
			kind_q    <= KIND_NONE;
			fail_q    <= 1'b0;
			host_q    <= 1'b0;
			type_hi_q <= `ZERO8;
			addr_hi_q <= `ZERO8;
		end else if (!en_q) begin
			idx_q   <= '0;
			shift_q <= '0;
			tag_q   <= TAG_NONE;
			kind_q  <= KIND_NONE;
			fail_q  <= 1'b1;
		end else if (tx_valid) begin
			idx_q <= (pos == `POS_MAX) ? pos : pos + 7'h01;
			if (tx_first) begin
				shift_q <= '0;
				tag_q   <= TAG_NONE;
				kind_q  <= KIND_NONE;
				fail_q  <= 1'b0;
				host_q  <= tx_port == `HOST_PORT;
			end else begin
				if (rel == `O_TYPE_HI && kind_q == KIND_NONE) begin
					type_hi_q <= tx_data;
				end
				if (rel == `O_TYPE_LO && kind_q == KIND_NONE && !fail_q) begin
					if (tval == `T_V6 && pctl_q[`B_V6]) begin
						kind_q <= KIND_V6;
					end else if (tval == `T_V4 && pctl_q[`B_V4]) begin
						kind_q <= KIND_V4;
					end else if (tval == vlan_q[`F_VLAN_A] && pctl_q[`B_VA] && tag_q == TAG_NONE) begin
						tag_q   <= TAG_A;
						shift_q <= shift_q + `TAG_LEN;
					end else if (tval == vlan_q[`F_VLAN_B] && pctl_q[`B_VB] && tag_q != TAG_B) begin
						tag_q   <= TAG_B;
						shift_q <= shift_q + `TAG_LEN;
					end else begin
						fail_q <= 1'b1;
					end
				end
				if ((kind_q == KIND_V6 && rel == `O_V6_DHI) || (kind_q == KIND_V4 && rel == `O_V4_DHI)) begin
					addr_hi_q <= tx_data;
				end
				if (bad) begin
					fail_q <= 1'b1;
				end
			end
		end
	end

	// Qualified frame waits for its SFD before the stamp is taken
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pend_q    <= 1'b0;
			pend_v6_q <= 1'b0;
			pend_mt_q <= 4'h0;
		end else if (!en_q) begin
			pend_q <= 1'b0;
		end else if (qual) begin
			pend_q    <= 1'b1;
			pend_v6_q <= kind_q == KIND_V6;
			pend_mt_q <= tx_data[3:0];
		end else if (tx_sfd_sent) begin
			pend_q <= 1'b0;
		end
	end

	assign push = tx_sfd_sent && pend_q && !qual;

	sync_event_fifo #(
		.W     (EW),
		.DEPTH (FIFO_DEPTH),
		.AW    (CW - 1)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n_q),
		.clr       (!en_q),
		.push      (push),
		.push_data ({pend_v6_q, pend_mt_q, ts_q}),
		.pop       (pop),
		.head      (head),
		.count     (cnt),
		.full      (full),
		.empty     (empty)
	);

	assign event_pending_raw = !empty;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n_q);

	pend_status_a: assert property (acc && !wb_we_i && wb_adr_i == `A_RAW_STAT |=> wb_dat_o[0] == ($past(cnt) != '0))
		else $error("pending bit disagrees with FIFO fill");
	annex_enable_a: assert property ($rose(pend_q) |-> (pend_v6_q ? pctl_q[`B_V6] : pctl_q[`B_V4]))
		else $error("event qualified with its annex disabled");
	host_port_a: assert property ($rose(pend_q) |-> host_q)
		else $error("non-host frame qualified");
	msg_type_a: assert property ($rose(pend_q) |-> msg_en[pend_mt_q])
		else $error("disabled message type qualified");
	sfd_push_a: assert property (tx_sfd_sent && pend_q && !qual && !full && !pop |=> cnt == $past(cnt) + 1'b1)
		else $error("SFD of qualified frame did not push");
	no_sfd_a: assert property (!tx_sfd_sent && !pop |=> cnt == $past(cnt) || !$past(en_q))
		else $error("event pushed without SFD");
	pop_head_a: assert property (pop && cnt != '0 && !push |=> cnt == $past(cnt) - 1'b1)
		else $error("pop did not remove head");
	held_reset_a: assert property (!en_q |=> ts_q == '0 && cnt == '0 && !pend_q)
		else $error("module not held while disabled");
	ref_stable_a: assert property (en_q |=> $stable(refsel_q))
		else $error("reference select changed while enabled");
	tag_shift_a: assert property (tag_q == TAG_B |-> shift_q == `TAG_LEN || shift_q == 7'h08)
		else $error("tag shift inconsistent with tags seen");

	cover_v6_c: cover property ($rose(pend_q) && pend_v6_q);
	cover_v4_c: cover property ($rose(pend_q) && !pend_v6_q);
	cover_two_tag_c: cover property (tag_q == TAG_B && shift_q == 7'h08 ##[1:60] qual);
	cover_pop_c: cover property (pop && cnt > 'd1);
endmodule
`default_nettype wire

// [verif/tx_frame_source.sv]
// Model of the switch transmit path: streams one frame's bytes, then pulses SFD.
// Assumes the bench fills frame[] and calls send and sfd right after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module tx_frame_source (
	// Clock
	input  wire logic       clk,
	// Byte stream
	output logic            tx_valid,
	output logic            tx_first,
	output logic [7:0]      tx_data,
	output logic [1:0]      tx_port,
	output logic            tx_sfd_sent
);
	logic [7:0] frame [0:79];

	initial begin
		tx_valid    = 1'b0;
		tx_first    = 1'b0;
		tx_data     = 8'hA5;
		tx_port     = 2'h0;
		tx_sfd_sent = 1'b0;
	end

	task automatic send(input logic [1:0] port, input int len);
		for (int i = 0; i < len; i++) begin
			tx_valid <= 1'b1;
			tx_first <= (i == 0);
			tx_data  <= frame[i];
			tx_port  <= port;
			@(posedge clk);
		end
		tx_valid <= 1'b0;
		tx_first <= 1'b0;
		// Idle line shows no stale byte
		tx_data  <= ~frame[len-1];
		tx_port  <= ~port;
	endtask

	// SFD only after the whole frame has gone by
	task automatic sfd();
		tx_sfd_sent <= 1'b1;
		@(posedge clk);
		tx_sfd_sent <= 1'b0;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// [verif/ptp_tx_packet_classifier_tb_top.sv]
// Self-checking bench: Wishbone register tasks plus frame table through the classifier.
// Assumes tx_frame_source as the transmit path and the register map of the design.
`timescale 1ns/1ps
`default_nettype none
`include "ptp_cls_cfg.svh"
module ptp_tx_packet_classifier_tb_top;
	import ptp_cls_pkg::*;
	logic            clk;
	logic            nrst;
	logic            wb_cyc_i;
	logic            wb_stb_i;
	logic            wb_we_i;
	logic [7:0]      wb_adr_i;
	logic [3:0]      wb_sel_i;
	word_t           wb_dat_i;
	word_t           wb_dat_o;
	logic            wb_ack_o;
	wire logic       tx_valid;
	wire logic       tx_first;
	wire logic [7:0] tx_data;
	wire logic [1:0] tx_port;
	wire logic       tx_sfd_sent;
	logic [4:0]      ref_clock_select;
	logic            event_pending_raw;
	int              err_count;
	int              checks_done;
	int              sh;
	word_t           q;

	ptp_tx_packet_classifier #(.FIFO_DEPTH(8), .SEL_W(5)) u_ptp_tx_packet_classifier (
		.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .tx_valid(tx_valid), .tx_first(tx_first), .tx_data(tx_data),
		.tx_port(tx_port), .tx_sfd_sent(tx_sfd_sent), .ref_clock_select(ref_clock_select),
		.event_pending_raw(event_pending_raw));

	tx_frame_source u_tx_frame_source (
		.clk(clk), .tx_valid(tx_valid), .tx_first(tx_first), .tx_data(tx_data),
		.tx_port(tx_port), .tx_sfd_sent(tx_sfd_sent));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic print_verdict();
		if (err_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Classic single cycle; waits for ack, no assumed latency
	task automatic xfer(input logic we, input logic [7:0] a, input word_t d, output word_t r);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		// Only the watchdog ends a wait that never sees ack
		do begin
			@(posedge clk);
		end while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input word_t d);
		word_t r;
		xfer(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, output word_t r);
		xfer(1'b0, a, 32'h0000_0000, r);
	endtask

	task automatic put(input int p, input logic [7:0] v);
		u_tx_frame_source.frame[p + sh] = v;
	endtask

	// nt bit0 = tag A, bit1 = tag B; positions given untagged
	task automatic build(input bit v6, input logic [1:0] nt, input int pos, input logic [7:0] val);
		int idx;
		idx = 12;
		for (int i = 0; i < 80; i++) u_tx_frame_source.frame[i] = 8'h00;
		if (nt[0]) begin
			u_tx_frame_source.frame[idx] = 8'h81;
			idx += 4;
		end
		if (nt[1]) begin
			u_tx_frame_source.frame[idx] = 8'h88;
			u_tx_frame_source.frame[idx+1] = 8'hA8;
			idx += 4;
		end
		sh = idx - 12;
		put(12, v6 ? 8'h86 : 8'h08);
		put(13, v6 ? 8'hDD : 8'h00);
		if (v6) begin
			put(14, 8'h60); put(20, 8'h11); put(21, 8'h01); put(38, 8'hFF); put(39, 8'h02);
			put(52, 8'h01); put(53, 8'h81); put(56, 8'h01); put(57, 8'h3F); put(62, 8'h03);
		end else begin
			put(14, 8'h45); put(23, 8'h11); put(30, 8'hE0); put(32, 8'h01); put(33, 8'h81);
			put(36, 8'h01); put(37, 8'h3F); put(42, 8'h03);
		end
		if (pos != 0) put(pos, val);
		// Address 107 pairs only with a zero high byte
		if (val == 8'h6B) put(pos - 1, 8'h00);
	endtask

	task automatic frame_out(input bit v6, input logic [1:0] nt, input logic [1:0] port,
			input int pos, input logic [7:0] val);
		build(v6, nt, pos, val);
		u_tx_frame_source.send(port, 80);
		@(posedge clk);
		u_tx_frame_source.sfd();
		@(posedge clk);
	endtask

	// One frame, pending checked, event read back and popped when expected
	task automatic run_case(input bit v6, input logic [1:0] nt, input logic [1:0] port,
			input int pos, input logic [7:0] val, input bit exp);
		word_t r;
		build(v6, nt, pos, val);
		u_tx_frame_source.send(port, 80);
		@(posedge clk);
		@(posedge clk);
		check("pending_before_sfd", event_pending_raw, 0);
		u_tx_frame_source.sfd();
		@(posedge clk);
		check("pending_after_sfd", event_pending_raw, exp);
		if (exp) begin
			rd(`A_EV_MID, r);
			check("event_mid", r, 32'h0000_0043);
			rd(`A_EV_HIGH, r);
			check("event_high", r, {31'h0, v6});
			wr(`A_POP, 32'h0000_0001);
			rd(`A_RAW_STAT, r);
			check("raw_status_popped", r, 32'h0000_0000);
		end
	endtask

	initial begin
		logic [7:0] regs [0:10];
		word_t      ts_first;
		regs = '{`A_TS_CTL, `A_REF_SEL, `A_RAW_STAT, `A_POP, `A_EV_LOW, `A_EV_MID, `A_EV_HIGH,
			`A_PORT_CTL, `A_ADDR_CTL, `A_CTL_TWO, 8'h30};
		err_count = 0;
		checks_done = 0;
		nrst = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0000_0000;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (regs[i]) begin
			rd(regs[i], q);
			check("reset_value", q, 32'h0000_0000);
		end
		wr(`A_REF_SEL, 32'h0000_000A);
		wr(`A_TS_CTL, 32'h0000_0001);
		wr(`A_REF_SEL, 32'h0000_0015);
		rd(`A_REF_SEL, q);
		check("ref_sel_locked", q, 32'h0000_000A);
		check("ref_sel_port", ref_clock_select, 5'h0A);
		wr(`A_PORT_CTL, 32'h000F_000F);
		wr(`A_ADDR_CTL, 32'h0000_00FE);
		wr(`A_CTL_TWO, 32'h0000_0004);
		wr(`A_VLAN, 32'h88A8_8100);
		run_case(0, 2'd0, 2'd0, 0, 8'h00, 1);
		run_case(0, 2'd1, 2'd0, 0, 8'h00, 1);
		run_case(0, 2'd2, 2'd0, 0, 8'h00, 1);
		run_case(0, 2'd3, 2'd0, 0, 8'h00, 1);
		run_case(0, 2'd0, 2'd0, 14, 8'h46, 0);
		run_case(0, 2'd0, 2'd0, 20, 8'h01, 0);
		run_case(0, 2'd0, 2'd0, 20, 8'hE0, 1);
		run_case(0, 2'd0, 2'd0, 21, 8'h01, 0);
		run_case(0, 2'd0, 2'd0, 22, 8'h05, 0);
		run_case(0, 2'd0, 2'd0, 23, 8'h06, 0);
		run_case(0, 2'd0, 2'd0, 33, 8'h85, 0);
		run_case(0, 2'd1, 2'd0, 33, 8'h84, 1);
		run_case(0, 2'd0, 2'd0, 37, 8'h40, 1);
		run_case(0, 2'd0, 2'd0, 37, 8'h41, 0);
		run_case(0, 2'd0, 2'd0, 42, 8'h05, 0);
		run_case(0, 2'd0, 2'd1, 0, 8'h00, 0);
		run_case(1, 2'd0, 2'd0, 0, 8'h00, 1);
		run_case(1, 2'd3, 2'd0, 0, 8'h00, 1);
		run_case(1, 2'd2, 2'd0, 14, 8'h6F, 1);
		run_case(1, 2'd0, 2'd0, 14, 8'h45, 0);
		run_case(1, 2'd0, 2'd0, 21, 8'h02, 0);
		run_case(1, 2'd0, 2'd0, 39, 8'h03, 0);
		run_case(1, 2'd0, 2'd0, 53, 8'h6B, 1);
		run_case(1, 2'd0, 2'd0, 57, 8'h40, 1);
		run_case(1, 2'd0, 2'd0, 62, 8'h07, 0);
		run_case(1, 2'd0, 2'd3, 0, 8'h00, 0);
		wr(`A_ADDR_CTL, 32'h0000_00FF);
		wr(`A_PORT_CTL, 32'h000F_001F);
		run_case(0, 2'd0, 2'd0, 33, 8'h85, 1);
		run_case(1, 2'd0, 2'd0, 53, 8'h99, 1);
		run_case(0, 2'd0, 2'd0, 22, 8'h05, 1);
		wr(`A_PORT_CTL, 32'h000F_001E);
		run_case(0, 2'd0, 2'd0, 0, 8'h00, 0);
		wr(`A_PORT_CTL, 32'h000F_001D);
		run_case(1, 2'd0, 2'd0, 0, 8'h00, 0);
		wr(`A_PORT_CTL, 32'h000F_001F);
		frame_out(0, 2'd0, 2'd0, 0, 8'h00);
		frame_out(1, 2'd0, 2'd0, 0, 8'h00);
		rd(`A_EV_LOW, ts_first);
		rd(`A_EV_HIGH, q);
		check("head_first", q, 32'h0000_0000);
		wr(`A_POP, 32'h0000_0001);
		rd(`A_EV_LOW, q);
		// SFD samples of the two frames lie 80 bytes plus four gap edges apart
		check("stamp_spacing", q - ts_first, 32'h0000_0054);
		rd(`A_EV_HIGH, q);
		check("head_second", q, 32'h0000_0001);
		rd(`A_RAW_STAT, q);
		check("raw_status_one_left", q, 32'h0000_0001);
		wr(`A_TS_CTL, 32'h0000_0000);
		check("pending_flushed", event_pending_raw, 0);
		frame_out(0, 2'd0, 2'd0, 0, 8'h00);
		check("disabled_no_event", event_pending_raw, 0);
		print_verdict();
	end

	initial begin
		#400000;
		err_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
